// File: logic/phpf_pkg.sv
`default_nettype none
package phpf_pkg;
    // apb register map, byte addresses
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_STATUS      = 8'h04;
    localparam logic [7:0]  ADDR_LAST_PKT    = 8'h08;
    // control register fields and reset value
    localparam int          CTRL_ALL_BIT     = 0;
    localparam int          CTRL_TBI_BIT     = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h0;
    // status register fields (bits 0 and 1 clear when written with one)
    localparam int          STAT_ALLFRM_BIT  = 0;
    localparam int          STAT_OVFL_BIT    = 1;
    localparam int          STAT_PEND_BIT    = 2;
    // packet identifiers
    localparam logic [7:0]  PKT_ID_BIW       = 8'h00;
    localparam logic [7:0]  PKT_ID_ADDR      = 8'h01;
    // block information format types
    localparam logic [2:0]  FMT_LOCAL_ZONE   = 3'h0;
    localparam logic [2:0]  FMT_DATE         = 3'h1;
    localparam logic [2:0]  FMT_TIME         = 3'h2;
    localparam logic [2:0]  FMT_SYSMSG       = 3'h5;
    localparam logic [2:0]  FMT_COUNTRY      = 3'h7;
    // vector types that start all-frame mode
    localparam logic [2:0]  VEC_SECURE       = 3'h0;
    localparam logic [2:0]  VEC_SHORT_INSTR  = 3'h1;
    localparam logic [2:0]  VEC_ALPHA        = 3'h5;
    localparam logic [2:0]  VEC_HEXBIN       = 3'h6;
    // error thresholds
    localparam logic [2:0]  ADDR_ERR_LIMIT   = 3'h3;
    localparam logic [2:0]  VEC_ERR_LIMIT    = 3'h2;
    // index at and above which the address is temporary or operator
    localparam logic [7:0]  IDX_TEMP_BASE    = 8'h80;
    // serial packet length
    localparam logic [5:0]  PKT_BITS         = 6'h20;
    localparam logic [31:0] PKT_RESET        = 32'h0000_0000;

    // serial link state, gray coded
    typedef enum logic [1:0] {
        PHPF_LK_IDLE  = 2'b00,
        PHPF_LK_SHIFT = 2'b01
    } phpf_link_t;
endpackage
`default_nettype wire

// File: logic/phpf_formatter.sv
// Summary of operation
// - reserved and zone/country words need all-info enable
// - date, time, system words need either enable
// - fourteen info bits copied raw for every format type
// - reserved formats carry raw bits, no layout
// - address packet only below three errors, matched
// - address packet top byte is one
// - byte two: bit7 priority, bit4 long
// - phase two-bit code, zero to three
// - eight-bit matched index reported as given
// - long address reports second word index once
// - tone-only bit only below index 128
// - vector word position in low seven bits
// - vector packet id is word position
// - long address first message follows vector
// - certain vector types enter all-frame mode
// - every non-tone address gets vector packet
// - bad vector sets error, withholds messages
// - numeric vector layout: position, flags, k,n,b
// - packets shifted out msb first
// - block info id zero, phase, error
`timescale 1ns/1ps
`default_nettype none
module phpf_formatter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // block information word event
    input  wire logic        biw_valid,
    input  wire logic [1:0]  biw_phase,
    input  wire logic [2:0]  biw_format,
    input  wire logic [13:0] biw_info,
    input  wire logic        biw_error,
    // address word event
    input  wire logic        addr_valid,
    input  wire logic [2:0]  addr_bit_errors,
    input  wire logic        addr_match,
    input  wire logic        priority_flag,
    input  wire logic [1:0]  addr_phase,
    input  wire logic        long_address_bit,
    input  wire logic [7:0]  matched_index,
    input  wire logic        addr_tone_only,
    input  wire logic [6:0]  vector_word_position,
    // vector word event
    input  wire logic        vec_valid,
    input  wire logic [6:0]  vec_word_pos,
    input  wire logic [1:0]  vec_phase,
    input  wire logic [2:0]  vec_type,
    input  wire logic [2:0]  vec_bit_errors,
    input  wire logic        vec_check_fail,
    input  wire logic        vec_long,
    input  wire logic [3:0]  vec_check_bits,
    input  wire logic [2:0]  vec_length,
    input  wire logic [6:0]  vec_msg_start,
    // message routing
    output var  logic        msg_enable,
    output var  logic [6:0]  msg_first_pos,
    output var  logic        all_frame_mode,
    // serial link to host
    input  wire logic        link_sclk,
    input  wire logic        link_cs_n,
    output var  logic        link_miso,
    output var  logic        packet_ready
);
    import phpf_pkg::*;

    logic [1:0]  ctrl_ff;
    logic        all_frame_ff;
    logic        ovfl_ff;
    logic [31:0] pend_ff;
    logic        pend_vld_ff;
    logic [31:0] last_ff;
    logic [31:0] shift_ff;
    logic [5:0]  bit_cnt_ff;
    phpf_link_t  link_st_ff;
    logic [1:0]  sclk_sync_ff;
    logic [1:0]  cs_sync_ff;
    logic        sclk_prev_ff;
    logic        cs_prev_ff;
    logic        biw_fwd;
    logic        ev_biw;
    logic        ev_addr;
    logic        ev_vec;
    logic        ev_any;
    logic        vec_err;
    logic        vec_allfrm;
    logic        take;
    logic        slot_free;
    logic        sclk_fall;
    logic        cs_fall;
    logic        apb_acc;
    logic        apb_wr;
    logic        clr_allfrm;
    logic        clr_ovfl;
    logic [31:0] nxt_pkt;

    // format types needing only the time enable
    function automatic logic fmt_is_time(input logic [2:0] f);
        return (f == FMT_DATE) || (f == FMT_TIME) || (f == FMT_SYSMSG);
    endfunction

    // block info word gating
    always_comb begin
        if (fmt_is_time(biw_format)) begin
            biw_fwd = ctrl_ff[CTRL_ALL_BIT] | ctrl_ff[CTRL_TBI_BIT];
        end else begin
            biw_fwd = ctrl_ff[CTRL_ALL_BIT];
        end
    end

    // event qualification
    assign ev_biw  = biw_valid & biw_fwd;
    assign ev_addr = addr_valid & addr_match & (addr_bit_errors < ADDR_ERR_LIMIT);
    assign ev_vec  = vec_valid;
    assign ev_any  = ev_biw | ev_addr | ev_vec;
    assign vec_err = (vec_bit_errors > VEC_ERR_LIMIT) | vec_check_fail;
    assign vec_allfrm = (vec_type == VEC_SECURE) | (vec_type == VEC_SHORT_INSTR)
                      | (vec_type == VEC_ALPHA) | (vec_type == VEC_HEXBIN);

    // packet build, vector first then address then block info
    always_comb begin
        nxt_pkt = PKT_RESET;
        if (ev_vec) begin
            nxt_pkt[31]    = 1'b0;
            nxt_pkt[30:24] = vec_word_pos;
            nxt_pkt[23]    = vec_err;
            nxt_pkt[22:21] = vec_phase;
            nxt_pkt[18:16] = vec_type;
            nxt_pkt[13:10] = vec_check_bits;
            nxt_pkt[9:7]   = vec_length;
            nxt_pkt[6:0]   = vec_msg_start;
        end else if (ev_addr) begin
            nxt_pkt[31:24] = PKT_ID_ADDR;
            nxt_pkt[23]    = priority_flag;
            nxt_pkt[22:21] = addr_phase;
            nxt_pkt[20]    = long_address_bit;
            nxt_pkt[15:8]  = matched_index;
            nxt_pkt[7]     = addr_tone_only & (matched_index < IDX_TEMP_BASE);
            nxt_pkt[6:0]   = vector_word_position;
        end else if (ev_biw) begin
            nxt_pkt[31:24] = PKT_ID_BIW;
            nxt_pkt[23]    = biw_error;
            nxt_pkt[22:21] = biw_phase;
            nxt_pkt[18:16] = biw_format;
            // fields already sit msb-first in the info bits for every type
            nxt_pkt[13:0]  = biw_info;
        end
    end

    // link input synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync_ff <= 2'h0;
            cs_sync_ff   <= 2'h3;
            sclk_prev_ff <= 1'b0;
            cs_prev_ff   <= 1'b1;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], link_sclk};
            cs_sync_ff   <= {cs_sync_ff[0], link_cs_n};
            sclk_prev_ff <= sclk_sync_ff[1];
            cs_prev_ff   <= cs_sync_ff[1];
        end
    end

    assign sclk_fall = sclk_prev_ff & ~sclk_sync_ff[1];
    assign cs_fall   = cs_prev_ff & ~cs_sync_ff[1];
    assign take      = cs_fall & pend_vld_ff;
    assign slot_free = ~pend_vld_ff | take;

    // pending packet slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff     <= PKT_RESET;
            pend_vld_ff <= 1'b0;
            last_ff     <= PKT_RESET;
        end else begin
            if (ev_any && slot_free) begin
                pend_ff     <= nxt_pkt;
                pend_vld_ff <= 1'b1;
                last_ff     <= nxt_pkt;
            end else if (take) begin
                pend_vld_ff <= 1'b0;
            end
        end
    end

    // serial shifter, msb first, data changes on falling sclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_st_ff <= PHPF_LK_IDLE;
            shift_ff   <= PKT_RESET;
            bit_cnt_ff <= 6'h0;
            link_miso  <= 1'b0;
        end else begin
            unique case (link_st_ff)
                PHPF_LK_IDLE: begin
                    if (cs_fall) begin
                        shift_ff   <= pend_vld_ff ? pend_ff : PKT_RESET;
                        link_miso  <= pend_vld_ff ? pend_ff[31] : 1'b0;
                        bit_cnt_ff <= 6'h0;
                        link_st_ff <= PHPF_LK_SHIFT;
                    end
                end
                PHPF_LK_SHIFT: begin
                    if (cs_sync_ff[1]) begin
                        link_st_ff <= PHPF_LK_IDLE;
                    end else if (sclk_fall && bit_cnt_ff != PKT_BITS) begin
                        shift_ff   <= {shift_ff[30:0], 1'b0};
                        link_miso  <= shift_ff[30];
                        bit_cnt_ff <= bit_cnt_ff + 6'h1;
                    end
                end
            endcase
        end
    end

    // host notification of a waiting packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            packet_ready <= 1'b0;
        end else begin
            packet_ready <= (pend_vld_ff & ~take) | (ev_any & slot_free);
        end
    end

    // apb decode
    assign apb_acc    = psel & penable & ~pready;
    assign apb_wr     = psel & penable & pready & pwrite; // write lands on the completing edge
    assign clr_allfrm = apb_wr & (paddr == ADDR_STATUS) & pwdata[STAT_ALLFRM_BIT];
    assign clr_ovfl   = apb_wr & (paddr == ADDR_STATUS) & pwdata[STAT_OVFL_BIT];

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (apb_wr && paddr == ADDR_CTRL) begin
            ctrl_ff <= pwdata[1:0];
        end
    end

    // all-frame mode, entry wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            all_frame_ff <= 1'b0;
        end else if (vec_valid && vec_allfrm) begin
            all_frame_ff <= 1'b1;
        end else if (clr_allfrm) begin
            all_frame_ff <= 1'b0;
        end
    end

    // overflow when an event finds the slot full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovfl_ff <= 1'b0;
        end else if (ev_any && !slot_free) begin
            ovfl_ff <= 1'b1;
        end else if (clr_ovfl) begin
            ovfl_ff <= 1'b0;
        end
    end

    // message routing outputs, enable and first position captured per vector, all-frame mode every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_enable     <= 1'b0;
            msg_first_pos  <= 7'h0;
            all_frame_mode <= 1'b0;
        end else begin
            all_frame_mode <= all_frame_ff;
            if (vec_valid) begin
                msg_enable    <= ~vec_err;
                msg_first_pos <= vec_long ? vec_word_pos + 7'h1 : vec_msg_start;
            end
        end
    end

    // apb response, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc & (paddr != ADDR_CTRL) & (paddr != ADDR_STATUS)
                     & (paddr != ADDR_LAST_PKT);
            prdata  <= 32'h0;
            if (apb_acc && !pwrite) begin
                unique case (paddr)
                    ADDR_CTRL:     prdata <= {30'h0, ctrl_ff};
                    ADDR_STATUS:   prdata <= {29'h0, pend_vld_ff, ovfl_ff, all_frame_ff};
                    ADDR_LAST_PKT: prdata <= last_ff;
                    default:       prdata <= 32'h0;
                endcase
            end
        end
    end

    // checks
    a_biw_gate: assert property (@(posedge pclk) disable iff (!presetn)
        biw_valid && !fmt_is_time(biw_format) && !ctrl_ff[CTRL_ALL_BIT] && !addr_valid
        && !vec_valid && !take |=> pend_ff == $past(pend_ff))
        else $error("gated block info word was loaded");
    a_biw_time: assert property (@(posedge pclk) disable iff (!presetn)
        biw_valid && fmt_is_time(biw_format) && ctrl_ff[CTRL_TBI_BIT] && !addr_valid
        && !vec_valid && slot_free |=> pend_ff[31:24] == PKT_ID_BIW
        && pend_ff[18:16] == $past(biw_format) && pend_ff[13:0] == $past(biw_info))
        else $error("time block info word not packed");
    a_biw_head: assert property (@(posedge pclk) disable iff (!presetn)
        ev_biw && !addr_valid && !vec_valid && slot_free |=> pend_ff[23] == $past(biw_error)
        && pend_ff[22:21] == $past(biw_phase))
        else $error("block info error or phase wrong");
    a_addr_drop: assert property (@(posedge pclk) disable iff (!presetn)
        addr_valid && addr_bit_errors >= 3'h3 && !biw_valid && !vec_valid
        |=> pend_ff == $past(pend_ff))
        else $error("address with three errors was loaded");
    a_addr_head: assert property (@(posedge pclk) disable iff (!presetn)
        ev_addr && !vec_valid && slot_free |=> pend_ff[31:24] == 8'h01
        && pend_ff[23] == $past(priority_flag) && pend_ff[20] == $past(long_address_bit)
        && pend_ff[15:8] == $past(matched_index))
        else $error("address packet header wrong");
    a_tone_temp: assert property (@(posedge pclk) disable iff (!presetn)
        ev_addr && !vec_valid && slot_free && matched_index >= 8'h80 |=> !pend_ff[7])
        else $error("tone-only set for temporary address");
    a_vec_pack: assert property (@(posedge pclk) disable iff (!presetn)
        ev_vec && slot_free |=> !pend_ff[31] && pend_ff[30:24] == $past(vec_word_pos)
        && pend_ff[9:7] == $past(vec_length) && pend_ff[6:0] == $past(vec_msg_start))
        else $error("vector packet layout wrong");
    a_vec_err: assert property (@(posedge pclk) disable iff (!presetn)
        vec_valid && vec_bit_errors == 3'h3 |=> !msg_enable ##1 !msg_enable || $past(vec_valid))
        else $error("messages not withheld for bad vector");
    a_all_frame: assert property (@(posedge pclk) disable iff (!presetn)
        vec_valid && (vec_type == 3'h5 || vec_type == 3'h6) |=> all_frame_ff ##1 all_frame_mode)
        else $error("all-frame mode not entered");
    a_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
        link_st_ff == PHPF_LK_IDLE && cs_fall && pend_vld_ff
        |=> link_miso == $past(pend_ff[31]) && shift_ff == $past(pend_ff))
        else $error("first bit out is not bit 31");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb ready not a single pulse");
    a_addr_pos: assert property (@(posedge pclk) disable iff (!presetn)
        ev_addr && !vec_valid && slot_free |=> pend_ff[6:0] == $past(vector_word_position)
        && pend_ff[22:21] == $past(addr_phase)) else $error("address position or phase wrong");
    a_vec_flags: assert property (@(posedge pclk) disable iff (!presetn)
        ev_vec && slot_free |=> pend_ff[23:21] == {$past(vec_err), $past(vec_phase)}
        && pend_ff[18:16] == $past(vec_type)) else $error("vector flags or type wrong");
    a_msg_start: assert property (@(posedge pclk) disable iff (!presetn)
        vec_valid && vec_long |=> msg_first_pos == $past(vec_word_pos) + 7'h1)
        else $error("long message start not after vector");
    a_shift_stop: assert property (@(posedge pclk) disable iff (!presetn)
        bit_cnt_ff == PKT_BITS |=> bit_cnt_ff == PKT_BITS || $past(cs_fall))
        else $error("shifter ran past the packet length");

    c_addr_load: cover property (@(posedge pclk) disable iff (!presetn) ev_addr && slot_free);
    c_vec_error: cover property (@(posedge pclk) disable iff (!presetn) ev_vec && vec_err);
    c_all_frame: cover property (@(posedge pclk) disable iff (!presetn) $rose(all_frame_ff));
    c_full_shift: cover property (@(posedge pclk) disable iff (!presetn) bit_cnt_ff == PKT_BITS);
endmodule
`default_nettype wire

// File: test/phpf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module phpf_host_model (
    output var  logic link_sclk,
    output var  logic link_cs_n,
    input  wire logic link_miso
);
    // link clock stands still and the device is deselected between frames
    initial begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
    end

    // one frame of 32 bits, sampled on each rising link edge, msb first
    task automatic read_packet(output logic [31:0] pkt);
        int i;
        link_cs_n = 1'b0;
        #41.3;                              // setup time well above four pclk
        for (i = 31; i >= 0; i--) begin
            link_sclk = 1'b1;
            pkt[i] = link_miso;
            #80;
            link_sclk = 1'b0;
            #80;
        end
        link_cs_n = 1'b1;
        #40;
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import phpf_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, matched_index = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, msg_enable, all_frame_mode, link_sclk, link_cs_n;
    logic        link_miso, packet_ready;
    logic        biw_valid = 1'b0, biw_error = 1'b0, addr_valid = 1'b0, addr_match = 1'b0;
    logic        priority_flag = 1'b0, long_address_bit = 1'b0, addr_tone_only = 1'b0;
    logic        vec_valid = 1'b0, vec_check_fail = 1'b0, vec_long = 1'b0;
    logic [1:0]  biw_phase = 2'h0, addr_phase = 2'h0, vec_phase = 2'h0;
    logic [2:0]  biw_format = 3'h0, addr_bit_errors = 3'h0, vec_type = 3'h0;
    logic [2:0]  vec_bit_errors = 3'h0, vec_length = 3'h0;
    logic [13:0] biw_info = 14'h0;
    logic [6:0]  vector_word_position = 7'h0, vec_word_pos = 7'h0, vec_msg_start = 7'h0;
    logic [6:0]  msg_first_pos;
    logic [3:0]  vec_check_bits = 4'h0;
    int          miscompares = 0, n_tests = 0, cycles = 0;

    phpf_formatter phpf_formatter_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .biw_valid, .biw_phase, .biw_format, .biw_info, .biw_error,
        .addr_valid, .addr_bit_errors, .addr_match, .priority_flag, .addr_phase,
        .long_address_bit, .matched_index, .addr_tone_only, .vector_word_position,
        .vec_valid, .vec_word_pos, .vec_phase, .vec_type, .vec_bit_errors,
        .vec_check_fail, .vec_long, .vec_check_bits, .vec_length, .vec_msg_start,
        .msg_enable, .msg_first_pos, .all_frame_mode, .link_sclk, .link_cs_n,
        .link_miso, .packet_ready
    );
    phpf_host_model phpf_host_model_i (.link_sclk, .link_cs_n, .link_miso);

    // 250 MHz clock
    initial begin
        forever #2 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // apb transfer: setup, access, hold until pready sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for a pending packet, reads it over the link, compares masked bits
    task automatic expect_pkt(input string what, input logic [31:0] exp, input logic [31:0] m);
        int i;
        logic [31:0] pkt;
        for (i = 0; i < 8 && packet_ready !== 1'b1; i++) @(posedge pclk);
        check({what, " ready"}, 32'h1, {31'h0, packet_ready});
        phpf_host_model_i.read_packet(pkt);
        check(what, exp & m, pkt & m);
        @(posedge pclk);
        check({what, " taken"}, 32'h0, {31'h0, packet_ready});
    endtask

    task automatic expect_none(input string what);
        repeat (4) @(posedge pclk);
        check(what, 32'h0, {31'h0, packet_ready});
    endtask

    task automatic pulse_biw(input logic [2:0] f, input logic [13:0] info, input logic e);
        @(posedge pclk);
        biw_phase <= f[1:0];
        biw_format <= f;
        biw_info <= info;
        biw_error <= e;
        biw_valid <= 1'b1;
        @(posedge pclk);
        biw_valid <= 1'b0;
    endtask

    task automatic pulse_addr(input logic [2:0] errs, input logic mt, input logic pri,
                              input logic [1:0] ph, input logic lng, input logic [7:0] idx,
                              input logic tone, input logic [6:0] pos);
        @(posedge pclk);
        addr_bit_errors <= errs;
        addr_match <= mt;
        priority_flag <= pri;
        addr_phase <= ph;
        long_address_bit <= lng;
        matched_index <= idx;
        addr_tone_only <= tone;
        vector_word_position <= pos;
        addr_valid <= 1'b1;
        @(posedge pclk);
        addr_valid <= 1'b0;
    endtask

    task automatic pulse_vec(input logic [6:0] pos, input logic [1:0] ph, input logic [2:0] ty,
                             input logic [2:0] errs, input logic fail, input logic lng);
        @(posedge pclk);
        vec_word_pos <= pos;
        vec_phase <= ph;
        vec_type <= ty;
        vec_bit_errors <= errs;
        vec_check_fail <= fail;
        vec_long <= lng;
        vec_check_bits <= 4'h9;
        vec_length <= 3'h2;
        vec_msg_start <= 7'h3c;
        vec_valid <= 1'b1;
        @(posedge pclk);
        vec_valid <= 1'b0;
    endtask

    // control register reset value and an unmapped address
    task automatic t_regs();
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl reset", {30'h0, CTRL_RESET}, rd);
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
    endtask

    // every format with neither enable, the time enable alone and the all-info enable alone
    task automatic t_biw();
        logic [1:0] ctl [3] = '{2'h0, 2'h2, 2'h1};
        logic       fwd;
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, ADDR_CTRL, {30'h0, ctl[c]});
            for (int f = 0; f < 8; f++) begin
                fwd = ctl[c][0] || (ctl[c][1] && (f == 1 || f == 2 || f == 5));
                pulse_biw(f[2:0], 14'h2a50 | f[13:0], f[0]);
                if (fwd) begin
                    expect_pkt("biw packet", {PKT_ID_BIW, f[0], f[1:0], 2'b00, f[2:0],
                               2'b00, 14'h2a50 | f[13:0]}, 32'hffff_ffff);
                end else begin
                    expect_none("biw gated");
                end
            end
        end
        apb(1'b1, ADDR_CTRL, 32'h0);
    endtask

    task automatic t_addr();
        pulse_addr(3'h3, 1'b1, 1'b0, 2'h1, 1'b0, 8'h02, 1'b0, 7'h10);
        expect_none("three errors");
        pulse_addr(3'h2, 1'b0, 1'b0, 2'h1, 1'b0, 8'h02, 1'b0, 7'h10);
        expect_none("no match");
        pulse_addr(3'h2, 1'b1, 1'b1, 2'h2, 1'b1, 8'h01, 1'b1, 7'h05);
        expect_pkt("tone long", {PKT_ID_ADDR, 1'b1, 2'h2, 1'b1, 4'h0, 8'h01, 1'b1, 7'h0},
                   32'hfff0_ff80);
        pulse_addr(3'h0, 1'b1, 1'b0, 2'h3, 1'b0, 8'h82, 1'b1, 7'h57);
        expect_pkt("temp index", {PKT_ID_ADDR, 1'b0, 2'h3, 1'b0, 4'h0, 8'h82, 1'b0, 7'h57},
                   32'hfff0_ffff);
        pulse_addr(3'h1, 1'b1, 1'b0, 2'h0, 1'b0, 8'h9f, 1'b0, 7'h02);
        expect_pkt("oper index", {PKT_ID_ADDR, 1'b0, 2'h0, 1'b0, 4'h0, 8'h9f, 1'b0, 7'h02},
                   32'hfff0_ffff);
    endtask

    // vector types, all-frame entry and its clearing, error vectors
    task automatic t_vec();
        logic [2:0] ty [7] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h3, 3'h4, 3'h7};
        logic [6:0] pos;
        logic       af, bad;
        for (int i = 0; i < 9; i++) begin
            pos = 7'h28 + i[6:0];
            bad = (i >= 7);
            af = !bad && i < 4;
            pulse_vec(pos, i[1:0], bad ? 3'h3 : ty[i], (i == 7) ? 3'h3 : 3'h2, i == 8, i[0]);
            expect_pkt("vector", {1'b0, pos, bad, i[1:0], 2'b00, bad ? 3'h3 : ty[i], 2'b00,
                       4'h9, 3'h2, 7'h3c}, 32'hffe7_ffff);
            check("all frame", {31'h0, af}, {31'h0, all_frame_mode});
            check("msg enable", {31'h0, !bad}, {31'h0, msg_enable});
            if (!bad) begin
                check("msg first", {25'h0, i[0] ? pos + 7'h1 : 7'h3c}, {25'h0, msg_first_pos});
            end
            apb(1'b1, ADDR_STATUS, 32'h1);
        end
    endtask

    // a second event while one is pending is lost and flagged
    task automatic t_ovfl();
        pulse_addr(3'h0, 1'b1, 1'b0, 2'h1, 1'b0, 8'h03, 1'b0, 7'h11);
        pulse_addr(3'h0, 1'b1, 1'b0, 2'h2, 1'b0, 8'h04, 1'b0, 7'h12);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("overflow status", 32'h6, rd & 32'h6);
        expect_pkt("kept packet", {PKT_ID_ADDR, 1'b0, 2'h1, 1'b0, 4'h0, 8'h03, 1'b0, 7'h11},
                   32'hfff0_ffff);
        apb(1'b0, ADDR_LAST_PKT, 32'h0);
        check("last packet", {PKT_ID_ADDR, 1'b0, 2'h1, 1'b0, 4'h0, 8'h03, 1'b0, 7'h11},
              rd & 32'hfff0_ffff);
        apb(1'b1, ADDR_STATUS, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("overflow cleared", 32'h0, rd & 32'h6);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_biw();
        t_addr();
        t_vec();
        t_ovfl();
        end_of_test();
    end
endmodule
`default_nettype wire
